// ### verilog/rtccw_pkg.sv
package rtccw_pkg;
  // register word addresses on the plain port
  localparam logic [2:0] RTCCW_A_CFG  = 3'h0; // clock_config_calibration
  localparam logic [2:0] RTCCW_A_TVAL = 3'h1; // time window (high/low bytes)
  localparam logic [2:0] RTCCW_A_ALCF = 3'h2; // alarm_config_repeat
  localparam logic [2:0] RTCCW_A_AVAL = 3'h3; // alarm window
  localparam logic [2:0] RTCCW_A_KEY  = 3'h4; // unlock_key_register
  localparam logic [2:0] RTCCW_A_PAD  = 3'h5; // output select
  // config fields
  localparam int RTCCW_B_EN    = 15;
  localparam int RTCCW_B_WREN  = 13;
  localparam int RTCCW_B_SYNC  = 12;
  localparam int RTCCW_B_HALF  = 11;
  localparam int RTCCW_B_OE    = 10;
  localparam int RTCCW_B_PTRH  = 9;
  localparam int RTCCW_B_PTRL  = 8;
  // alarm config fields, then the output select bit of the output select register
  localparam int RTCCW_B_AEN   = 15;
  localparam int RTCCW_B_CHIME = 14;
  localparam int RTCCW_B_MSKH  = 13;
  localparam int RTCCW_B_MSKL  = 10;
  localparam int RTCCW_B_SECSEL = 1;
  // unlock key bytes
  localparam logic [7:0] RTCCW_KEY1 = 8'h55;
  localparam logic [7:0] RTCCW_KEY2 = 8'hAA;
  // crystal rate and derived counts
  localparam int RTCCW_XTAL_HZ   = 32768;
  localparam int RTCCW_HALF_TICKS = RTCCW_XTAL_HZ / 2;
  localparam int RTCCW_CAL_STEP  = 4;
  // alarm period codes
  localparam logic [3:0] RTCCW_M_HALF = 4'h0;
  localparam logic [3:0] RTCCW_M_SEC  = 4'h1;
  localparam logic [3:0] RTCCW_M_10S  = 4'h2;
  localparam logic [3:0] RTCCW_M_MIN  = 4'h3;
  localparam logic [3:0] RTCCW_M_10M  = 4'h4;
  localparam logic [3:0] RTCCW_M_HOUR = 4'h5;
  localparam logic [3:0] RTCCW_M_DAY  = 4'h6;
  localparam logic [3:0] RTCCW_M_WEEK = 4'h7;
  localparam logic [3:0] RTCCW_M_MON  = 4'h8;
  localparam logic [3:0] RTCCW_M_YEAR = 4'h9;
  // unlock sequence states
  typedef enum logic [1:0] {
    RTCCW_K_IDLE = 2'b00,
    RTCCW_K_GOT1 = 2'b01,
    RTCCW_K_OPEN = 2'b10
  } rtccw_key_t;
  // bcd limits
  localparam logic [7:0] RTCCW_BCD59 = 8'h59;
  localparam logic [7:0] RTCCW_BCD23 = 8'h23;
  localparam logic [7:0] RTCCW_BCD12 = 8'h12;
  localparam logic [7:0] RTCCW_BCD99 = 8'h99;
  localparam logic [7:0] RTCCW_BCD01 = 8'h01;
  localparam logic [7:0] RTCCW_BCD06 = 8'h06;
  localparam logic [7:0] RTCCW_BCD02 = 8'h02;
  localparam logic [7:0] RTCCW_BCD28 = 8'h28;
  localparam logic [7:0] RTCCW_BCD29 = 8'h29;
  localparam logic [7:0] RTCCW_BCD30 = 8'h30;
  localparam logic [7:0] RTCCW_BCD31 = 8'h31;
endpackage : rtccw_pkg

// ### verilog/rtccw_top.sv
// Design decisions made here: the address map and the address-and-strobe port.
module rtccw_top
  import rtccw_pkg::*;
#(
  parameter int RIPPLE_LEAD = 32 // ticks before a second edge that flag ripple
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        xtal_tick,   // one-cycle pulse per 32.768 kHz edge
  input  wire logic [2:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic [1:0]  reg_wbe,     // byte enables: [1] high, [0] low
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  output logic             clock_pin,
  output logic             alarm_evt
);

  // all state in one record
  typedef struct packed {
    logic [7:0]  sec, min, hr, wd, day, mon, yr;
    logic [7:0]  asec, amin, ahr, awd, aday, amon;
    logic        en, wren, oe;
    logic [1:0]  tptr;
    logic [7:0]  cal;
    logic        aen, chime;
    logic [3:0]  alarm_period_select;
    logic [1:0]  aptr;
    logic [7:0]  alarm_repeat_count;
    logic        secsel;
    logic [14:0] pre;      // crystal ticks within a half second
    logic        half;
    logic [10:0] skip;     // ticks still to swallow or insert
    logic        skip_add;
    rtccw_key_t  key;
    logic        key_gap;  // one spare cycle after the key
    logic [15:0] rdata;
    logic        pin;
    logic        aevt;
  } rtccw_st_t;

  rtccw_st_t st_reg, st_next;

  // bcd increment of one byte
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    logic [7:0] r;
    r = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    return r;
  endfunction

  // last day of month, leap years on years divisible by four
  function automatic logic [7:0] month_end(input logic [7:0] m, input logic [7:0] y);
    logic leap;
    leap = ((y[4] == 1'b0) && (y[1:0] == 2'b00)) || ((y[4] == 1'b1) && (y[1:0] == 2'b10));
    if (m == RTCCW_BCD02) begin
      month_end = leap ? RTCCW_BCD29 : RTCCW_BCD28;
    end else if ((m == 8'h04) || (m == 8'h06) || (m == 8'h09) || (m == 8'h11)) begin
      month_end = RTCCW_BCD30;
    end else begin
      month_end = RTCCW_BCD31;
    end
  endfunction

  logic        half_wrap;   // prescaler reaches end of half second
  logic        sec_step;    // second boundary
  logic        min_wrap;
  logic        alarm_hit;
  logic        wr_key_ok;
  logic [15:0] tval, aval;

  // window read multiplexers
  always_comb begin
    case (st_reg.tptr)
      2'b00:   tval = {st_reg.min, st_reg.sec};
      2'b01:   tval = {st_reg.wd, st_reg.hr};
      2'b10:   tval = {st_reg.mon, st_reg.day};
      default: tval = {8'h00, st_reg.yr};
    endcase
    case (st_reg.aptr)
      2'b00:   aval = {st_reg.amin, st_reg.asec};
      2'b01:   aval = {st_reg.awd, st_reg.ahr};
      2'b10:   aval = {st_reg.amon, st_reg.aday};
      default: aval = 16'h0000;
    endcase
  end

  // next-state logic
  always_comb begin
    st_next   = st_reg;
    st_next.aevt = 1'b0;
    wr_key_ok = (st_reg.key == RTCCW_K_OPEN);
    half_wrap = 1'b0;
    sec_step  = 1'b0;
    min_wrap  = 1'b0;
    alarm_hit = 1'b0;
    // prescaler: calibration swallows or doubles ticks; each unit loads
    // four of them, and each moves the count by one crystal pulse
    if (st_reg.en && xtal_tick) begin
      if (st_reg.skip != 11'h000 && !st_reg.skip_add) begin
        st_next.skip = st_reg.skip - 11'h001;
      end else begin
        if (st_reg.skip != 11'h000) begin
          st_next.skip = st_reg.skip - 11'h001;
          st_next.pre  = st_reg.pre + 15'h0002;
        end else begin
          st_next.pre = st_reg.pre + 15'h0001;
        end
        if (st_next.pre >= 15'(RTCCW_HALF_TICKS)) begin
          st_next.pre  = st_next.pre - 15'(RTCCW_HALF_TICKS);
          half_wrap    = 1'b1;
          st_next.half = ~st_reg.half;
          sec_step     = st_reg.half;
        end
      end
    end
    // calendar ripple
    if (sec_step) begin
      if (st_reg.sec == RTCCW_BCD59) begin
        st_next.sec = 8'h00;
        min_wrap    = 1'b1;
        if (st_reg.min == RTCCW_BCD59) begin
          st_next.min = 8'h00;
          if (st_reg.hr == RTCCW_BCD23) begin
            st_next.hr = 8'h00;
            st_next.wd = (st_reg.wd == RTCCW_BCD06) ? 8'h00 : bcd_inc(st_reg.wd);
            if (st_reg.day == month_end(st_reg.mon, st_reg.yr)) begin
              st_next.day = RTCCW_BCD01;
              if (st_reg.mon == RTCCW_BCD12) begin
                st_next.mon = RTCCW_BCD01;
                st_next.yr  = (st_reg.yr == RTCCW_BCD99) ? 8'h00 : bcd_inc(st_reg.yr);
              end else begin
                st_next.mon = bcd_inc(st_reg.mon);
              end
            end else begin
              st_next.day = bcd_inc(st_reg.day);
            end
          end else begin
            st_next.hr = bcd_inc(st_reg.hr);
          end
        end else begin
          st_next.min = bcd_inc(st_reg.min);
        end
      end else begin
        st_next.sec = bcd_inc(st_reg.sec);
      end
    end
    // once a minute load the calibration correction
    if (min_wrap && st_reg.cal != 8'h00) begin
      st_next.skip_add = ~st_reg.cal[7];
      st_next.skip     = st_reg.cal[7] ? 11'({~st_reg.cal + 8'h01, 2'b00})
                                       : 11'({st_reg.cal, 2'b00});
    end
    // alarm compare on the value just entered, at each half second
    if (half_wrap && st_reg.aen) begin
      case (st_reg.alarm_period_select)
        RTCCW_M_HALF: alarm_hit = 1'b1;
        RTCCW_M_SEC:  alarm_hit = sec_step;
        RTCCW_M_10S:  alarm_hit = sec_step && st_next.sec[3:0] == st_reg.asec[3:0];
        RTCCW_M_MIN:  alarm_hit = sec_step && st_next.sec == st_reg.asec;
        RTCCW_M_10M:  alarm_hit = sec_step && st_next.sec == st_reg.asec
                                  && st_next.min[3:0] == st_reg.amin[3:0];
        RTCCW_M_HOUR: alarm_hit = sec_step && {st_next.min, st_next.sec}
                                  == {st_reg.amin, st_reg.asec};
        RTCCW_M_DAY:  alarm_hit = sec_step && {st_next.hr, st_next.min, st_next.sec}
                                  == {st_reg.ahr, st_reg.amin, st_reg.asec};
        RTCCW_M_WEEK: alarm_hit = sec_step && {st_next.wd, st_next.hr, st_next.min,
                                  st_next.sec} == {st_reg.awd, st_reg.ahr, st_reg.amin,
                                  st_reg.asec};
        RTCCW_M_MON:  alarm_hit = sec_step && {st_next.day, st_next.hr, st_next.min,
                                  st_next.sec} == {st_reg.aday, st_reg.ahr, st_reg.amin,
                                  st_reg.asec};
        RTCCW_M_YEAR: alarm_hit = sec_step && {st_next.mon, st_next.day, st_next.hr,
                                  st_next.min, st_next.sec} == {st_reg.amon, st_reg.aday,
                                  st_reg.ahr, st_reg.amin, st_reg.asec};
        default:      alarm_hit = 1'b0; // reserved codes never fire
      endcase
    end
    if (alarm_hit) begin
      st_next.aevt = 1'b1;
      if (st_reg.alarm_repeat_count != 8'h00 || st_reg.chime) begin
        st_next.alarm_repeat_count = st_reg.alarm_repeat_count - 8'h01;
      end else begin
        st_next.aen = 1'b0;
      end
    end
    // output pin: seconds clock or alarm pulse
    st_next.pin = st_reg.oe && (st_reg.secsel ? st_next.half : st_next.aevt);
    // key sequence window: one spare cycle allowed after 0xAA
    if (st_reg.key == RTCCW_K_OPEN) begin
      if (st_reg.key_gap) begin
        st_next.key = RTCCW_K_IDLE;
      end
      st_next.key_gap = 1'b1;
    end
    if (reg_wr && reg_addr == RTCCW_A_KEY) begin
      st_next.key_gap = 1'b0;
      if (reg_wdata[7:0] == RTCCW_KEY1) begin
        st_next.key = RTCCW_K_GOT1;
      end else if (reg_wdata[7:0] == RTCCW_KEY2 && st_reg.key == RTCCW_K_GOT1) begin
        st_next.key = RTCCW_K_OPEN;
      end else begin
        st_next.key = RTCCW_K_IDLE;
      end
    end else if (reg_wr || (st_reg.key == RTCCW_K_GOT1)) begin
      if (st_reg.key == RTCCW_K_GOT1) begin
        st_next.key = RTCCW_K_IDLE;
      end
    end
    // register writes
    if (reg_wr) begin
      if (reg_addr == RTCCW_A_CFG) begin
        if (reg_wbe[1]) begin
          // enable may only rise right after the key
          if (reg_wdata[RTCCW_B_WREN] && !st_reg.wren) begin
            st_next.wren = wr_key_ok;
          end else begin
            st_next.wren = reg_wdata[RTCCW_B_WREN];
          end
          if (st_reg.wren) begin
            st_next.en = reg_wdata[RTCCW_B_EN];
          end
          st_next.oe   = reg_wdata[RTCCW_B_OE];
          st_next.tptr = reg_wdata[RTCCW_B_PTRH:RTCCW_B_PTRL];
          st_next.key  = RTCCW_K_IDLE;
        end
        if (reg_wbe[0]) begin
          st_next.cal = reg_wdata[7:0];
        end
      end else if (reg_addr == RTCCW_A_TVAL) begin
        if (st_reg.wren) begin
          if (reg_wbe[0]) begin
            case (st_reg.tptr)
              2'b00: begin
                st_next.sec  = reg_wdata[7:0];
                st_next.half = 1'b0; // seconds write restarts the second
                st_next.pre  = 15'h0000;
              end
              2'b01:   st_next.hr  = reg_wdata[7:0];
              2'b10:   st_next.day = reg_wdata[7:0];
              default: st_next.yr  = reg_wdata[7:0];
            endcase
          end
          if (reg_wbe[1]) begin
            case (st_reg.tptr)
              2'b00:   st_next.min = reg_wdata[15:8];
              2'b01:   st_next.wd  = reg_wdata[15:8];
              2'b10:   st_next.mon = reg_wdata[15:8];
              default: st_next.min = st_next.min; // high byte empty here
            endcase
          end
        end
        if (reg_wbe[1] && st_reg.tptr != 2'b00) begin
          st_next.tptr = st_reg.tptr - 2'b01;
        end
      end else if (reg_addr == RTCCW_A_ALCF) begin
        if (reg_wbe[1]) begin
          st_next.aen   = reg_wdata[RTCCW_B_AEN];
          st_next.chime = reg_wdata[RTCCW_B_CHIME];
          st_next.alarm_period_select = reg_wdata[RTCCW_B_MSKH:RTCCW_B_MSKL];
          st_next.aptr  = reg_wdata[RTCCW_B_PTRH:RTCCW_B_PTRL];
        end
        if (reg_wbe[0]) begin
          st_next.alarm_repeat_count = reg_wdata[7:0];
        end
      end else if (reg_addr == RTCCW_A_AVAL) begin
        if (reg_wbe[0]) begin
          case (st_reg.aptr)
            2'b00:   st_next.asec = reg_wdata[7:0];
            2'b01:   st_next.ahr  = reg_wdata[7:0];
            2'b10:   st_next.aday = reg_wdata[7:0];
            default: st_next.asec = st_next.asec; // unimplemented pair
          endcase
        end
        if (reg_wbe[1]) begin
          case (st_reg.aptr)
            2'b00:   st_next.amin = reg_wdata[15:8];
            2'b01:   st_next.awd  = reg_wdata[15:8];
            2'b10:   st_next.amon = reg_wdata[15:8];
            default: st_next.amin = st_next.amin;
          endcase
          if (st_reg.aptr != 2'b00) begin
            st_next.aptr = st_reg.aptr - 2'b01;
          end
        end
      end else if (reg_addr == RTCCW_A_PAD) begin
        st_next.secsel = reg_wdata[RTCCW_B_SECSEL];
      end
    end
    // register reads, data valid the next cycle
    st_next.rdata = 16'h0000;
    if (reg_rd) begin
      if (reg_addr == RTCCW_A_CFG) begin
        st_next.rdata = {st_reg.en, 1'b0, st_reg.wren,
                         st_reg.en && (st_reg.half && st_reg.pre
                         >= 15'(RTCCW_HALF_TICKS - RIPPLE_LEAD)),
                         st_reg.half, st_reg.oe, st_reg.tptr, st_reg.cal};
      end else if (reg_addr == RTCCW_A_TVAL) begin
        st_next.rdata = tval;
        if (st_reg.tptr != 2'b00) begin
          st_next.tptr = st_reg.tptr - 2'b01;
        end
      end else if (reg_addr == RTCCW_A_ALCF) begin
        st_next.rdata = {st_reg.aen, st_reg.chime, st_reg.alarm_period_select, st_reg.aptr, st_reg.alarm_repeat_count};
      end else if (reg_addr == RTCCW_A_AVAL) begin
        st_next.rdata = aval;
        if (st_reg.aptr != 2'b00) begin
          st_next.aptr = st_reg.aptr - 2'b01;
        end
      end else if (reg_addr == RTCCW_A_PAD) begin
        st_next.rdata = {14'h0000, st_reg.secsel, 1'b0};
      end else begin
        st_next.rdata = 16'h0000; // unmapped reads as zero
      end
    end
  end

  // state register; calendar resets to 2000-01-01 00:00:00
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_reg      <= '0;
      st_reg.day  <= RTCCW_BCD01;
      st_reg.mon  <= RTCCW_BCD01;
      st_reg.aday <= RTCCW_BCD01;
      st_reg.amon <= RTCCW_BCD01;
      st_reg.key  <= RTCCW_K_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;
  assign clock_pin = st_reg.pin;
  assign alarm_evt = st_reg.aevt;

  // checks
  chk_wren_locked: assert property (@(posedge core_clk) disable iff (rst)
    (!st_reg.wren && reg_wr && reg_addr == RTCCW_A_TVAL && !sec_step) |=> $stable(st_reg.min))
    else $error("time changed while locked");
  chk_wren_key: assert property (@(posedge core_clk) disable iff (rst)
    $rose(st_reg.wren) |-> $past(st_reg.key) == RTCCW_K_OPEN)
    else $error("write enable set without key");
  chk_tptr_floor: assert property (@(posedge core_clk) disable iff (rst)
    (reg_rd && reg_addr == RTCCW_A_TVAL && st_reg.tptr == 2'b00) |=> st_reg.tptr == 2'b00)
    else $error("time pointer went below zero");
  chk_tptr_dec: assert property (@(posedge core_clk) disable iff (rst)
    (reg_rd && reg_addr == RTCCW_A_TVAL && st_reg.tptr != 2'b00)
    |=> st_reg.tptr == $past(st_reg.tptr) - 2'b01)
    else $error("time read did not step pointer");
  chk_aptr_dec: assert property (@(posedge core_clk) disable iff (rst)
    (reg_wr && reg_addr == RTCCW_A_AVAL && reg_wbe[1] && st_reg.aptr != 2'b00)
    |=> st_reg.aptr == $past(st_reg.aptr) - 2'b01)
    else $error("alarm high write did not step pointer");
  chk_hours_range: assert property (@(posedge core_clk) disable iff (rst)
    (st_reg.hr <= RTCCW_BCD23 && !reg_wr) |=> (st_reg.hr <= RTCCW_BCD23))
    else $error("hours left range");
  chk_sec_roll: assert property (@(posedge core_clk) disable iff (rst)
    (sec_step && st_reg.sec == RTCCW_BCD59 && !reg_wr) |=> st_reg.sec == 8'h00)
    else $error("seconds did not roll");
  chk_alarm_off: assert property (@(posedge core_clk) disable iff (rst)
    (alarm_hit && st_reg.alarm_repeat_count == 8'h00 && !st_reg.chime && !reg_wr) |=> !st_reg.aen)
    else $error("alarm did not self clear");
  chk_cal_load: assert property (@(posedge core_clk) disable iff (rst)
    (min_wrap && st_reg.cal == 8'h01) |=> (st_reg.skip == 11'h004 && st_reg.skip_add))
    else $error("calibration step not four pulses");
  chk_rd_latency: assert property (@(posedge core_clk) disable iff (rst)
    !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outside its cycle");
  cov_alarm: cover property (@(posedge core_clk) alarm_evt);
  cov_unlock: cover property (@(posedge core_clk) $rose(st_reg.wren));
  cov_year: cover property (@(posedge core_clk) sec_step && st_reg.mon == RTCCW_BCD12
    && st_reg.day == RTCCW_BCD31 && st_reg.hr == RTCCW_BCD23);

endmodule // rtccw_top

// ### sim/rtccw_top_bench.sv
module rtccw_top_bench
  import rtccw_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int TIMEOUT_CYCLES = 80000; // one crystal second of ticks plus margin

  logic        core_clk;     // 125 mhz core clock
  logic        rst;          // sync reset, active high
  logic        xtal_tick;    // crystal edge pulse
  logic [2:0]  reg_addr;     // register word address
  logic [15:0] reg_wdata;    // write data
  logic [1:0]  reg_wbe;      // byte enables
  logic        reg_wr;       // write strobe
  logic        reg_rd;       // read strobe
  logic [15:0] reg_rdata;    // read data, cycle after read
  logic        clock_pin;    // output pin
  logic        alarm_evt;    // alarm pulse
  int          bad_count;    // mismatches seen
  int          total_checks; // comparisons made
  int          cycles;       // run length so far
  int          alarms;       // alarm pulses seen
  int          base;         // alarm count before a run
  logic [15:0] got;          // last read value

  rtccw_top #(.RIPPLE_LEAD(32)) u_dut (
    .core_clk  (core_clk),
    .rst       (rst),
    .xtal_tick (xtal_tick),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wbe   (reg_wbe),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata),
    .clock_pin (clock_pin),
    .alarm_evt (alarm_evt)
  );

  // free-running clock, 8 ns period
  always #4 core_clk = ~core_clk;

  // watchdog and alarm pulse counter
  always @(posedge core_clk) begin
    cycles++;
    if (alarm_evt === 1'b1) begin
      alarms++;
    end
    if (cycles == TIMEOUT_CYCLES) begin
      bad_count++; // a hang counts as a mismatch
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // one compare for every 16-bit result
  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] seen);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // write: called just after an edge, taken at the next one; strobe left up
  // so a following write can go back to back
  task automatic wr(input logic [2:0] a, input logic [15:0] d, input logic [1:0] be);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wbe   <= be;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
  endtask

  // one cycle with no strobe
  task automatic idle();
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask

  // read: data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_wr   <= 1'b0;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge core_clk);
  endtask

  // read, mask off fields not under test, compare
  task automatic rd_chk(input logic [2:0] a, input logic [15:0] m, input logic [15:0] exp,
                        input string what);
    logic [15:0] v;
    rd(a, v);
    chk16(what, exp, v & m);
  endtask

  // crystal pulses, one every second core cycle
  task automatic run_ticks(input int n);
    repeat (n) begin
      xtal_tick <= 1'b1;
      @(posedge core_clk);
      xtal_tick <= 1'b0;
      @(posedge core_clk);
    end
  endtask

  // values straight after reset
  task automatic t_reset();
    rd_chk(RTCCW_A_CFG, 16'hFFFF, 16'h0000, "config after reset");
    rd_chk(RTCCW_A_TVAL, 16'hFFFF, 16'h0000, "min sec after reset");
    rd_chk(3'h7, 16'hFFFF, 16'h0000, "unmapped read");
  endtask

  // walk the time window down by reads, pointer floors at zero
  task automatic t_time_ptr();
    wr(RTCCW_A_CFG, 16'h0300, 2'b11);
    rd_chk(RTCCW_A_TVAL, 16'hFFFF, 16'h0000, "year pair");
    rd_chk(RTCCW_A_CFG, 16'h0300, 16'h0200, "time ptr after read");
    rd_chk(RTCCW_A_TVAL, 16'hFFFF, 16'h0101, "month day pair");
    rd_chk(RTCCW_A_TVAL, 16'h00FF, 16'h0000, "hours");
    rd_chk(RTCCW_A_TVAL, 16'hFFFF, 16'h0000, "min sec pair");
    rd_chk(RTCCW_A_CFG, 16'h0300, 16'h0000, "time ptr floor");
  endtask

  // key sequence with too long a gap, then a legal one, then locked writes
  task automatic t_unlock();
    wr(RTCCW_A_KEY, {8'h00, RTCCW_KEY1}, 2'b01);
    wr(RTCCW_A_KEY, {8'h00, RTCCW_KEY2}, 2'b01);
    idle();
    idle();
    wr(RTCCW_A_CFG, 16'h2000, 2'b11);
    rd_chk(RTCCW_A_CFG, 16'h2000, 16'h0000, "enable after late set");
    wr(RTCCW_A_KEY, {8'h00, RTCCW_KEY1}, 2'b01);
    wr(RTCCW_A_KEY, {8'h00, RTCCW_KEY2}, 2'b01);
    idle();
    wr(RTCCW_A_CFG, 16'h2300, 2'b11);
    rd_chk(RTCCW_A_CFG, 16'h2300, 16'h2300, "enable after key");
    wr(RTCCW_A_TVAL, 16'h0099, 2'b11);
    wr(RTCCW_A_TVAL, 16'h0015, 2'b01);
    rd_chk(RTCCW_A_CFG, 16'h0300, 16'h0200, "ptr after low write");
    rd_chk(RTCCW_A_TVAL, 16'hFFFF, 16'h0115, "day written");
    wr(RTCCW_A_CFG, 16'h0200, 2'b11);
    wr(RTCCW_A_TVAL, 16'h0731, 2'b11);
    rd_chk(RTCCW_A_CFG, 16'h2300, 16'h0100, "locked write steps ptr");
    wr(RTCCW_A_CFG, 16'h0300, 2'b11);
    rd_chk(RTCCW_A_TVAL, 16'hFFFF, 16'h0099, "year written");
    rd_chk(RTCCW_A_TVAL, 16'hFFFF, 16'h0115, "locked write ignored");
  endtask

  // alarm window written high to low, read back, unimplemented pair
  task automatic t_alarm();
    wr(RTCCW_A_ALCF, 16'h0200, 2'b11);
    wr(RTCCW_A_AVAL, 16'h1231, 2'b11);
    rd_chk(RTCCW_A_ALCF, 16'h0300, 16'h0100, "alarm ptr step");
    wr(RTCCW_A_AVAL, 16'h0623, 2'b11);
    wr(RTCCW_A_AVAL, 16'h5958, 2'b11);
    rd_chk(RTCCW_A_ALCF, 16'h0300, 16'h0000, "alarm ptr floor");
    wr(RTCCW_A_ALCF, 16'h0200, 2'b11);
    rd_chk(RTCCW_A_AVAL, 16'hFFFF, 16'h1231, "alarm month day");
    rd_chk(RTCCW_A_AVAL, 16'hFFFF, 16'h0623, "alarm wday hours");
    rd_chk(RTCCW_A_AVAL, 16'hFFFF, 16'h5958, "alarm min sec");
    wr(RTCCW_A_ALCF, 16'h0300, 2'b11);
    rd_chk(RTCCW_A_AVAL, 16'hFFFF, 16'h0000, "alarm pair 11");
  endtask

  // one second from the last second of a leap february day
  task automatic t_run();
    wr(RTCCW_A_KEY, {8'h00, RTCCW_KEY1}, 2'b01);
    wr(RTCCW_A_KEY, {8'h00, RTCCW_KEY2}, 2'b01);
    wr(RTCCW_A_CFG, 16'hA300, 2'b11);
    wr(RTCCW_A_TVAL, 16'h0000, 2'b11);
    wr(RTCCW_A_TVAL, 16'h0228, 2'b11);
    wr(RTCCW_A_TVAL, 16'h0223, 2'b11);
    wr(RTCCW_A_TVAL, 16'h5959, 2'b11);
    wr(RTCCW_A_CFG, 16'h8701, 2'b11);
    wr(RTCCW_A_ALCF, 16'h8000, 2'b11);
    wr(RTCCW_A_PAD, 16'h0002, 2'b11);
    rd_chk(RTCCW_A_PAD, 16'hFFFF, 16'h0002, "pad select");
    base = alarms;
    run_ticks(RTCCW_HALF_TICKS + 16);
    chk16("seconds clock high", 16'h0001, {15'h0000, clock_pin});
    rd_chk(RTCCW_A_CFG, 16'h1800, 16'h0800, "second half flag");
    run_ticks(RTCCW_HALF_TICKS - 24);
    rd_chk(RTCCW_A_CFG, 16'h1800, 16'h1800, "ripple flag near roll");
    run_ticks(24);
    chk16("seconds clock low", 16'h0000, {15'h0000, clock_pin});
    rd_chk(RTCCW_A_TVAL, 16'hFFFF, 16'h0000, "year after run");
    rd_chk(RTCCW_A_TVAL, 16'hFFFF, 16'h0229, "leap day");
    rd_chk(RTCCW_A_TVAL, 16'hFFFF, 16'h0300, "wday hours roll");
    rd_chk(RTCCW_A_TVAL, 16'hFFFF, 16'h0000, "min sec roll");
    chk16("alarm pulses", 16'h0001, 16'(alarms - base));
    rd_chk(RTCCW_A_ALCF, 16'hFFFF, 16'h0000, "alarm self clear");
  endtask

  // main sequence
  initial begin
    core_clk     = 1'b0;
    rst          = 1'b1;
    xtal_tick    = 1'b0;
    reg_addr     = 3'h0;
    reg_wdata    = 16'h0000;
    reg_wbe      = 2'b00;
    reg_wr       = 1'b0;
    reg_rd       = 1'b0;
    bad_count    = 0;
    total_checks = 0;
    cycles       = 0;
    alarms       = 0;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_time_ptr();
    t_unlock();
    t_alarm();
    t_run();
    print_verdict();
  end
endmodule // rtccw_top_bench
